/* hdl/lse_pkg.sv */
// package: opcodes, condition types, instruction layout, step counts
package lse_pkg;

	// instruction words are 16 bits wide; device operands are 8 bits
	localparam int WORD_W = 16;
	localparam int DEV_W = 8;
	localparam int DEV_NUM = 256;
	localparam int NEST_W = 3;
	localparam int IN_BASE = 0;
	localparam int OUT_BASE = 128;
	localparam logic [2:0] STEP_ONE = 3'h1;
	localparam logic [2:0] STEP_OUT = 3'h3;
	localparam logic [2:0] STEP_GATE = 3'h5;
	localparam logic RESET_ACC = 1'h0;

	// opcode encodings held in instruction memory
	typedef enum logic [4:0] {
		OP_IDLE = 5'h00,
		OP_LOAD_OPEN = 5'h01,
		OP_LOAD_CLOSED = 5'h02,
		OP_AND = 5'h03,
		OP_AND_INV = 5'h04,
		OP_OR = 5'h05,
		OP_OR_INV = 5'h06,
		OP_BLK_AND = 5'h07,
		OP_BLK_OR = 5'h08,
		OP_PUSH = 5'h09,
		OP_PEEK = 5'h0a,
		OP_POP = 5'h0b,
		OP_OUT = 5'h0c,
		OP_SET = 5'h0d,
		OP_CLEAR = 5'h0e,
		OP_RISE_PULSE = 5'h0f,
		OP_FALL_PULSE = 5'h10,
		OP_SHIFT = 5'h11,
		OP_SHIFT_EDGE = 5'h12,
		OP_GATE_BEGIN = 5'h13,
		OP_GATE_END = 5'h14,
		OP_END = 5'h15,
		OP_LINE_BREAK = 5'h16
	} lse_op_e;

	// execution condition types
	typedef enum logic [2:0] {
		XC_ALWAYS = 3'h0,
		XC_HIGH = 3'h1,
		XC_RISE = 3'h2,
		XC_LOW = 3'h3,
		XC_FALL = 3'h4
	} lse_xc_e;

	// one 16-bit instruction word
	typedef struct packed {
		lse_op_e op;
		lse_xc_e xc;
		logic [DEV_W-1:0] dev;
	} lse_instr_s;

endpackage

/* hdl/lse_sequence_executor.sv */
// sequence instruction executor: one instruction per clock, one scan per pass
`timescale 1ns/10ps
`default_nettype none

module lse_sequence_executor #(
	parameter int PROG_DEPTH = 256,
	parameter int IN_NUM = 16,
	parameter int OUT_NUM = 16,
	parameter int STACK_DEPTH = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic runEn,
	output logic [$clog2(PROG_DEPTH)-1:0] progAddr,
	input wire lse_pkg::lse_instr_s progWord,
	input wire logic [IN_NUM-1:0] inPins,
	output logic [OUT_NUM-1:0] outPins,
	output logic scanDone,
	output logic running
);
	localparam int PC_W = $clog2(PROG_DEPTH);

	// elaboration-time checks
	if (PROG_DEPTH < 8 || (1 << PC_W) != PROG_DEPTH)
		$error("PROG_DEPTH must be a power of two of at least 8");
	if (IN_NUM < 1 || IN_NUM > lse_pkg::OUT_BASE)
		$error("IN_NUM out of range");
	if (OUT_NUM < 1 || lse_pkg::OUT_BASE + OUT_NUM > lse_pkg::DEV_NUM)
		$error("OUT_NUM out of range");
	if (STACK_DEPTH < 2)
		$error("STACK_DEPTH must be at least 2");
	if ($bits(lse_pkg::lse_instr_s) != lse_pkg::WORD_W)
		$error("instruction word must be 16 bits");

	logic [IN_NUM-1:0] syncA, syncB, syncC, inFilt;
	logic [PC_W-1:0] pc, next_pc;
	logic acc, next_acc;
	logic [STACK_DEPTH-1:0] blkStk, next_blkStk;
	logic [STACK_DEPTH-1:0] resStk, next_resStk;
	logic [(1<<lse_pkg::NEST_W)-1:0] gateOff, next_gateOff;
	logic [lse_pkg::DEV_NUM-1:0] devBits, next_devBits;
	logic [PROG_DEPTH-1:0] prevCond, next_prevCond;
	logic [OUT_NUM-1:0] next_outPins;
	logic next_scanDone;
	logic cond, bitVal, rise, fall, exec;
	lse_pkg::lse_xc_e xcEff;
	logic [2:0] steps;

	// input pins: three stages, accept change once stages two and three agree
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			syncA <= '0;
			syncB <= '0;
			syncC <= '0;
			inFilt <= '0;
		end else begin
			syncA <= inPins;
			syncB <= syncA;
			syncC <= syncB;
			if (syncB == syncC)
				inFilt <= syncC;
		end
	end

	// condition evaluation for the instruction at the current step
	always_comb begin
		// a gate begin with its condition off forces every following condition off until gate end
		// gated condition
		cond = acc & ~(|gateOff);
		bitVal = devBits[progWord.dev];
		rise = cond & ~prevCond[pc];
		fall = ~cond & prevCond[pc];
		case (progWord.op)
			lse_pkg::OP_RISE_PULSE: xcEff = lse_pkg::XC_RISE;
			lse_pkg::OP_FALL_PULSE: xcEff = lse_pkg::XC_FALL;
			lse_pkg::OP_SHIFT_EDGE: xcEff = lse_pkg::XC_RISE;
			lse_pkg::OP_OUT: xcEff = lse_pkg::XC_ALWAYS;
			default: xcEff = progWord.xc;
		endcase
		case (xcEff)
			lse_pkg::XC_ALWAYS: exec = cond;
			lse_pkg::XC_HIGH: exec = cond;
			lse_pkg::XC_RISE: exec = rise;
			lse_pkg::XC_LOW: exec = ~cond;
			lse_pkg::XC_FALL: exec = fall;
			default: exec = 1'b0;
		endcase
		case (progWord.op)
			lse_pkg::OP_OUT, lse_pkg::OP_SET, lse_pkg::OP_CLEAR,
			lse_pkg::OP_RISE_PULSE, lse_pkg::OP_FALL_PULSE,
			lse_pkg::OP_SHIFT, lse_pkg::OP_SHIFT_EDGE,
			lse_pkg::OP_GATE_END: steps = lse_pkg::STEP_OUT;
			lse_pkg::OP_GATE_BEGIN: steps = lse_pkg::STEP_GATE;
			default: steps = lse_pkg::STEP_ONE;
		endcase
	end

	// executor next state: one instruction per clock while enabled
	always_comb begin
		next_pc = pc;
		next_acc = acc;
		next_blkStk = blkStk;
		next_resStk = resStk;
		next_gateOff = gateOff;
		next_devBits = devBits;
		next_prevCond = prevCond;
		next_outPins = outPins;
		next_scanDone = 1'b0;
		if (runEn) begin
			next_pc = pc + PC_W'(steps);
			next_prevCond[pc] = cond;
			case (progWord.op)
				lse_pkg::OP_LOAD_OPEN: begin
					next_blkStk = {blkStk[STACK_DEPTH-2:0], acc};
					next_acc = bitVal;
				end
				lse_pkg::OP_LOAD_CLOSED: begin
					next_blkStk = {blkStk[STACK_DEPTH-2:0], acc};
					next_acc = ~bitVal;
				end
				lse_pkg::OP_AND: next_acc = acc & bitVal;
				lse_pkg::OP_AND_INV: next_acc = acc & ~bitVal;
				lse_pkg::OP_OR: next_acc = acc | bitVal;
				lse_pkg::OP_OR_INV: next_acc = acc | ~bitVal;
				lse_pkg::OP_BLK_AND: begin
					next_acc = acc & blkStk[0];
					next_blkStk = {1'b0, blkStk[STACK_DEPTH-1:1]};
				end
				lse_pkg::OP_BLK_OR: begin
					next_acc = acc | blkStk[0];
					next_blkStk = {1'b0, blkStk[STACK_DEPTH-1:1]};
				end
				lse_pkg::OP_PUSH: next_resStk = {resStk[STACK_DEPTH-2:0], acc};
				lse_pkg::OP_PEEK: next_acc = resStk[0];
				lse_pkg::OP_POP: begin
					next_acc = resStk[0];
					next_resStk = {1'b0, resStk[STACK_DEPTH-1:1]};
				end
				lse_pkg::OP_OUT: next_devBits[progWord.dev] = cond;
				lse_pkg::OP_SET: begin
					if (exec)
						next_devBits[progWord.dev] = 1'b1;
				end
				lse_pkg::OP_CLEAR: begin
					if (exec)
						next_devBits[progWord.dev] = 1'b0;
				end
				lse_pkg::OP_RISE_PULSE: next_devBits[progWord.dev] = exec;
				lse_pkg::OP_FALL_PULSE: next_devBits[progWord.dev] = exec;
				lse_pkg::OP_SHIFT, lse_pkg::OP_SHIFT_EDGE: begin
					if (exec && progWord.dev != '0) begin
						next_devBits[progWord.dev] =
							devBits[progWord.dev - 8'h01];
						next_devBits[progWord.dev - 8'h01] = 1'b0;
					end
				end
				lse_pkg::OP_GATE_BEGIN:
					next_gateOff[progWord.dev[lse_pkg::NEST_W-1:0]] = ~cond;
				lse_pkg::OP_GATE_END: begin
					for (int i = 0; i < (1 << lse_pkg::NEST_W); i++) begin
						if (i >= int'(progWord.dev[lse_pkg::NEST_W-1:0]))
							next_gateOff[i] = 1'b0;
					end
				end
				lse_pkg::OP_END: begin
					next_pc = '0;
					next_scanDone = 1'b1;
					next_acc = lse_pkg::RESET_ACC;
					next_blkStk = '0;
					next_resStk = '0;
					next_gateOff = '0;
					next_devBits[lse_pkg::IN_BASE +: IN_NUM] = inFilt;
					next_outPins = devBits[lse_pkg::OUT_BASE +: OUT_NUM];
				end
				default: ;
			endcase
		end
	end

	// executor registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pc <= '0;
			acc <= lse_pkg::RESET_ACC;
			blkStk <= '0;
			resStk <= '0;
			gateOff <= '0;
			devBits <= '0;
			prevCond <= '0;
			outPins <= '0;
			scanDone <= 1'b0;
		end else begin
			pc <= next_pc;
			acc <= next_acc;
			blkStk <= next_blkStk;
			resStk <= next_resStk;
			gateOff <= next_gateOff;
			devBits <= next_devBits;
			prevCond <= next_prevCond;
			outPins <= next_outPins;
			scanDone <= next_scanDone;
		end
	end

	assign progAddr = pc;
	assign running = runEn;

	// checks on executed instructions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	AST_OUT_FOLLOWS: assert property (
		runEn && progWord.op == lse_pkg::OP_OUT
		|=> devBits[$past(progWord.dev)] == $past(cond))
		else $error("output does not follow condition");
	AST_SET_SKIP: assert property (
		runEn && progWord.op == lse_pkg::OP_SET && xcEff == lse_pkg::XC_HIGH
		&& !cond |=> $stable(devBits))
		else $error("set processed while condition off");
	AST_RISE_ONCE: assert property (
		runEn && progWord.op == lse_pkg::OP_RISE_PULSE && cond
		&& prevCond[pc] |=> !devBits[$past(progWord.dev)])
		else $error("rising pulse held past one scan");
	AST_FALL_ONCE: assert property (
		runEn && progWord.op == lse_pkg::OP_FALL_PULSE && !cond
		&& prevCond[pc] |=> devBits[$past(progWord.dev)])
		else $error("falling pulse missed");
	AST_LOAD: assert property (
		runEn && progWord.op == lse_pkg::OP_LOAD_CLOSED
		|=> acc == !$past(bitVal) && pc == $past(pc) + PC_W'(1))
		else $error("load closed wrong");
	AST_POP: assert property (
		runEn && progWord.op == lse_pkg::OP_POP
		|=> acc == $past(resStk[0]) && resStk[0] == $past(resStk[1]))
		else $error("pop did not discard");
	AST_END: assert property (
		runEn && progWord.op == lse_pkg::OP_END
		|=> pc == '0 && scanDone ##1 !scanDone)
		else $error("end did not restart scan");
	AST_GATE_STEPS: assert property (
		runEn && progWord.op == lse_pkg::OP_GATE_BEGIN
		|=> pc == $past(pc) + PC_W'(5))
		else $error("gate begin step count wrong");
	AST_OUT_STEPS: assert property (
		runEn && progWord.op == lse_pkg::OP_OUT
		|=> pc == $past(pc) + PC_W'(3))
		else $error("output step count wrong");
	AST_GATED: assert property (
		runEn && progWord.op == lse_pkg::OP_GATE_BEGIN && !cond
		|=> !cond)
		else $error("gate did not force condition off");
	AST_IDLE: assert property (
		runEn && progWord.op == lse_pkg::OP_IDLE
		|=> $stable(devBits) && $stable(acc))
		else $error("idle step changed state");

	CVR_SCAN: cover property (runEn && progWord.op == lse_pkg::OP_END);
	CVR_PULSE: cover property (
		runEn && progWord.op == lse_pkg::OP_RISE_PULSE && rise);
	CVR_GATE: cover property (
		runEn && progWord.op == lse_pkg::OP_GATE_BEGIN && !cond);
	CVR_SHIFT: cover property (
		runEn && progWord.op == lse_pkg::OP_SHIFT_EDGE && exec);
endmodule

`default_nettype wire

/* test/lse_prog_mem.sv */
// instruction memory model holding the ladder test program
`timescale 1ns/10ps
`default_nettype none
module lse_prog_mem #(
	parameter int AW = 8
) (
	input wire logic [AW-1:0] addr,
	output var lse_pkg::lse_instr_s word
);
	lse_pkg::lse_instr_s mem [2**AW];
	int a;

	// place one word, then step over the words it does not use
	task automatic p(input logic [4:0] op, input logic [7:0] dev,
		input logic [2:0] xc = 3'h0);
		mem[a] = {op, xc, dev};
		a += (op >= 5'h0c && op <= 5'h14) ? ((op == 5'h13) ? 5 : 3) : 1;
	endtask

	// unused words hold an end so a stray fetch shows at once
	initial begin
		a = 0;
		foreach (mem[i]) begin
			mem[i] = {5'h15, 3'h0, 8'hff};
		end
		p(5'h01, 8'h00);
		p(5'h03, 8'h01);
		p(5'h0c, 8'h80);
		p(5'h02, 8'h02);
		p(5'h06, 8'h03);
		p(5'h0c, 8'h81);
		p(5'h01, 8'h04);
		p(5'h0f, 8'h82);
		p(5'h01, 8'h04);
		p(5'h10, 8'h83);
		p(5'h01, 8'h05);
		p(5'h0d, 8'h84, 3'h1);
		p(5'h01, 8'h06);
		p(5'h0e, 8'h84, 3'h2);
		p(5'h01, 8'h07);
		p(5'h09, 8'h00);
		p(5'h03, 8'h08);
		p(5'h0c, 8'h85);
		p(5'h0a, 8'h00);
		p(5'h04, 8'h08);
		p(5'h0c, 8'h86);
		p(5'h0b, 8'h00);
		p(5'h0c, 8'h89);
		p(5'h00, 8'h00);
		p(5'h16, 8'h00);
		p(5'h01, 8'h09);
		p(5'h01, 8'h0a);
		p(5'h05, 8'h0b);
		p(5'h07, 8'h00);
		p(5'h0c, 8'h87);
		p(5'h01, 8'h0c);
		p(5'h0d, 8'h88, 3'h3);
		p(5'h01, 8'h0d);
		p(5'h0e, 8'h88, 3'h4);
		p(5'h01, 8'h0e);
		p(5'h13, 8'h01);
		p(5'h01, 8'h0f);
		p(5'h0c, 8'h8a);
		p(5'h14, 8'h01);
		p(5'h01, 8'h0f);
		p(5'h0c, 8'h8b);
		p(5'h0c, 8'h8c);
		p(5'h0c, 8'h8e);
		p(5'h01, 8'h0e);
		p(5'h11, 8'h8d, 3'h1);
		p(5'h12, 8'h8f);
		p(5'h15, 8'h00);
	end

	// asynchronous read port
	assign word = mem[addr];
endmodule
`default_nettype wire

/* test/test_ladder_sequence_executor.sv */
// self-checking bench for the ladder sequence executor
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
	err_total++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module test_ladder_sequence_executor;
	logic mclk = 1'h0;
	logic nrst = 1'h0;
	logic runEn = 1'h0;
	logic [15:0] inPins = 16'h0000;
	logic [7:0] progAddr;
	lse_pkg::lse_instr_s progWord;
	logic [15:0] outPins;
	logic scanDone;
	logic running;
	logic [7:0] expAddr;
	logic [31:0] lfsr = 32'ha7b8b642;
	logic [15:0] d;
	logic [15:0] pv = 16'h0000;
	logic [15:0] ex;
	logic s4 = 1'h0;
	// the scan before the first inputs sees all zero, so level-low sets
	logic s8 = 1'h1;
	logic s13 = 1'h0;
	logic s15 = 1'h0;
	bit armed = 1'b0;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	lse_sequence_executor uut (
		.mclk(mclk), .nrst(nrst), .runEn(runEn), .progAddr(progAddr),
		.progWord(progWord), .inPins(inPins), .outPins(outPins),
		.scanDone(scanDone), .running(running)
	);
	lse_prog_mem mem0 (.addr(progAddr), .word(progWord));

	function automatic logic [31:0] nextRand(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// next fetch address from the step length of each opcode
	function automatic logic [7:0] stepNext(input logic [7:0] a,
		input lse_pkg::lse_op_e op);
		if (op == lse_pkg::OP_END) return 8'h00;
		if (op == lse_pkg::OP_GATE_BEGIN) return a + 8'h05;
		if (op >= lse_pkg::OP_OUT && op <= lse_pkg::OP_GATE_END) begin
			return a + 8'h03;
		end
		return a + 8'h01;
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic waitScan();
		int n;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (scanDone !== 1'b1 && n < 300);
		`CHK("restart", 8'h00, progAddr)
		`CHK("scanDone", 1'b1, scanDone)
		`CHK("running", 1'b1, running)
	endtask

	// fetch address check on every rising clock edge but the first after reset, plus run-time ceiling
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			armed = 1'b0;
		end else begin
			cyc++;
			if (armed) `CHK("progAddr", expAddr, progAddr)
			expAddr = runEn ? stepNext(progAddr, progWord.op) : progAddr;
			armed = 1'b1;
			if (cyc > 20000) begin
				err_total++;
				results();
			end
		end
	end

	// random inputs per pass, two scans each, outputs against the model
	initial begin
		repeat (5) @(negedge mclk);
		nrst <= 1'h1;
		runEn <= 1'h1;
		@(negedge mclk);
		`CHK("outPins", 16'h0000, outPins)
		for (int i = 0; i < 60; i++) begin
			lfsr = nextRand(lfsr);
			d = lfsr[15:0];
			inPins <= d;
			runEn <= 1'h0;
			repeat (3) @(negedge mclk);
			`CHK("running", 1'b0, running)
			runEn <= 1'h1;
			waitScan();
			waitScan();
			// first scan runs on the previous inputs, second on these
			s4 = (s4 | pv[5] | d[5]) & ~(d[6] & ~pv[6]);
			s8 = (s8 | ~pv[12] | ~d[12]) & ~(pv[13] & ~d[13]);
			if (pv[14])
				s13 = pv[15];
			if (d[14])
				s13 = d[15];
			if (d[14] & ~pv[14])
				s15 = d[15];
			ex = {s15, d[15] & ~(d[14] & ~pv[14]), s13, d[15] & ~d[14],
				d[15], d[15] & d[14], d[7], s8, d[9] & (d[10] | d[11]),
				d[7] & ~d[8], d[7] & d[8], s4, ~d[4] & pv[4],
				d[4] & ~pv[4], ~d[2] | ~d[3], d[0] & d[1]};
			`CHK("outPins", ex, outPins)
			`CHK("outBlk", ex[9:5], outPins[9:5])
			`CHK("outGate", ex[15:10], outPins[15:10])
			pv = d;
			$display("scan test %0d done", i);
		end
		results();
	end
endmodule
`default_nettype wire
